// >>> rtl/oin_notify_server.sv
`timescale 1ns/10ps
module oin_notify_server
  import oin_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic broadcast_in,
  input wire logic [7:0] seq_in,
  input wire logic [7:0] payload_type_in,
  input wire logic [7:0] jitter_in,
  input wire logic [15:0] mfr_code_in,
  input wire logic [15:0] image_type_in,
  input wire logic [31:0] file_version_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  output logic tx_broadcast_out,
  output logic busy_out,
  output logic [7:0] tx_src_ep_out,
  output logic [7:0] tx_dst_ep_out,
  output logic [15:0] tx_cluster_out,
  output logic [15:0] tx_profile_out,
  output logic [7:0] notify_compat_out,
  output logic [23:0] notify_fw_out,
  output logic notify_fs_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  input wire logic [7:0] rx_src_ep_in,
  input wire logic [7:0] rx_dst_ep_in,
  input wire logic [15:0] rx_cluster_in,
  input wire logic [15:0] rx_profile_in,
  output logic rx_query_out,
  output logic rx_other_out,
  output logic [7:0] rx_seq_out,
  output logic [7:0] rx_cmd_out,
  output logic [7:0] rx_compat_out,
  output logic [23:0] rx_fw_out,
  input wire logic file_restart_in,
  input wire logic file_valid_in,
  input wire logic [7:0] file_data_in,
  output logic file_hdr_done_out,
  output logic [15:0] file_tag_out,
  output logic [31:0] file_length_out,
  output logic file_is_image_out,
  output logic file_data_valid_out,
  output logic [7:0] file_data_out,
  output logic file_data_last_out
);
  // ****************
  // Notify byte selection
  // ****************
  function automatic logic [7:0] notify_byte(input logic [3:0] idx, input logic bcast,
      input logic [7:0] seq, input logic [7:0] ptype, input logic [7:0] jit,
      input logic [15:0] mfr, input logic [15:0] itype, input logic [31:0] ver);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      OIN_OFS_FC: b = bcast ? OIN_FC_BROADCAST : OIN_FC_UNICAST;
      OIN_OFS_SEQ: b = seq;
      OIN_OFS_CMD: b = OIN_CMD_NOTIFY;
      OIN_OFS_PTYPE: b = ptype;
      OIN_OFS_JITTER: b = jit;
      default:
      begin
        // Little-endian fields at fixed offsets
        if (idx >= OIN_OFS_VER)
          b = ver[(idx - OIN_OFS_VER)*8 +: 8];
        else if (idx >= OIN_OFS_ITYPE)
          b = itype[(idx - OIN_OFS_ITYPE)*8 +: 8];
        else if (idx >= OIN_OFS_MFR)
          b = mfr[(idx - OIN_OFS_MFR)*8 +: 8];
      end
    endcase
    return b;
  endfunction

  // ****************
  // Notify transmitter
  // ****************
  oin_tx_state_type tx_state_r, tx_state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] len_r, len_nxt;
  logic bc_r, bc_nxt;
  logic [7:0] seq_r, seq_nxt;
  logic [7:0] pt_r, pt_nxt;
  logic [7:0] jit_r, jit_nxt;
  logic [15:0] mfr_r, mfr_nxt;
  logic [15:0] it_r, it_nxt;
  logic [31:0] ver_r, ver_nxt;
  logic tv_r, tv_nxt;
  logic [7:0] td_r, td_nxt;
  logic tl_r, tl_nxt;

  always_comb
  begin
    tx_state_nxt = tx_state_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    bc_nxt = bc_r;
    seq_nxt = seq_r;
    pt_nxt = pt_r;
    jit_nxt = jit_r;
    mfr_nxt = mfr_r;
    it_nxt = it_r;
    ver_nxt = ver_r;
    tv_nxt = tv_r;
    td_nxt = td_r;
    tl_nxt = tl_r;
    case (tx_state_r)
      OIN_TX_IDLE:
      begin
        // The only way this server opens an upgrade
        if (start_in)
        begin
          tx_state_nxt = OIN_TX_LOAD;
          bc_nxt = broadcast_in;
          seq_nxt = seq_in;
          // Out-of-range payload types are sent as type 3
          pt_nxt = (payload_type_in > OIN_PTYPE_MAX) ? OIN_PTYPE_MAX : payload_type_in;
          if (!broadcast_in)
            jit_nxt = OIN_JITTER_MAX;
          else
            jit_nxt = (jitter_in > OIN_JITTER_MAX) ? OIN_JITTER_MAX : jitter_in;
          case (pt_nxt[1:0])
            2'h0: len_nxt = OIN_LEN_PT0;
            2'h1: len_nxt = OIN_LEN_PT1;
            2'h2: len_nxt = OIN_LEN_PT2;
            default: len_nxt = OIN_LEN_PT3;
          endcase
          mfr_nxt = mfr_code_in;
          it_nxt = image_type_in;
          ver_nxt = file_version_in;
        end
      end
      OIN_TX_LOAD:
      begin
        tv_nxt = 1'b1;
        td_nxt = notify_byte(4'h0, bc_r, seq_r, pt_r, jit_r, mfr_r, it_r, ver_r);
        tl_nxt = 1'b0;
        idx_nxt = 4'h1;
        tx_state_nxt = OIN_TX_SEND;
      end
      OIN_TX_SEND:
      begin
        if (tx_ready_in)
        begin
          if (tl_r)
          begin
            tv_nxt = 1'b0;
            tl_nxt = 1'b0;
            tx_state_nxt = OIN_TX_IDLE;
          end
          else
          begin
            td_nxt = notify_byte(idx_r, bc_r, seq_r, pt_r, jit_r, mfr_r, it_r, ver_r);
            tl_nxt = (idx_r == len_r - 4'h1);
            idx_nxt = idx_r + 4'h1;
          end
        end
      end
      default:
      begin
        tx_state_nxt = OIN_TX_IDLE;
        tv_nxt = 1'b0;
        tl_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      tx_state_r <= OIN_TX_IDLE;
      idx_r <= 4'h0;
      len_r <= OIN_LEN_PT0;
      bc_r <= 1'b0;
      seq_r <= 8'h00;
      pt_r <= 8'h00;
      jit_r <= OIN_JITTER_MAX;
      mfr_r <= 16'h0000;
      it_r <= 16'h0000;
      ver_r <= 32'h0000_0000;
      tv_r <= 1'b0;
      td_r <= 8'h00;
      tl_r <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_state_r <= tx_state_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      bc_r <= bc_nxt;
      seq_r <= seq_nxt;
      pt_r <= pt_nxt;
      jit_r <= jit_nxt;
      mfr_r <= mfr_nxt;
      it_r <= it_nxt;
      ver_r <= ver_nxt;
      tv_r <= tv_nxt;
      td_r <= td_nxt;
      tl_r <= tl_nxt;
    end
  end

  // ****************
  // Request receiver; only the byte index restarts between frames, field registers keep their bytes
  // ****************
  logic [4:0] ridx_r, ridx_nxt;
  logic addr_ok_r, addr_ok_nxt;
  logic [7:0] rfc_r, rfc_nxt;
  logic [7:0] rseq_r, rseq_nxt;
  logic [7:0] rcmd_r, rcmd_nxt;
  logic [31:0] rver_r, rver_nxt;
  logic rq_r, rq_nxt;
  logic ro_r, ro_nxt;
  logic [7:0] oseq_r, oseq_nxt;
  logic [7:0] ocmd_r, ocmd_nxt;
  logic [31:0] over_r, over_nxt;
  logic addr_ok_now;

  always_comb
  begin
    ridx_nxt = ridx_r;
    addr_ok_nxt = addr_ok_r;
    rfc_nxt = rfc_r;
    rseq_nxt = rseq_r;
    rcmd_nxt = rcmd_r;
    rver_nxt = rver_r;
    rq_nxt = 1'b0;
    ro_nxt = 1'b0;
    oseq_nxt = oseq_r;
    ocmd_nxt = ocmd_r;
    over_nxt = over_r;
    addr_ok_now = (rx_src_ep_in == OIN_ENDPOINT) && (rx_dst_ep_in == OIN_ENDPOINT) &&
        (rx_cluster_in == OIN_CLUSTER_ID) && (rx_profile_in == OIN_PROFILE_ID);
    if (rx_valid_in)
    begin
      if (ridx_r == 5'h00)
        addr_ok_nxt = addr_ok_now;
      case (ridx_r)
        5'h00: rfc_nxt = rx_data_in;
        5'h01: rseq_nxt = rx_data_in;
        5'h02: rcmd_nxt = rx_data_in;
        default:
        begin
          if ((ridx_r >= OIN_RQ_OFS_VER) && (ridx_r < OIN_RQ_MIN_LEN))
            rver_nxt[(ridx_r - OIN_RQ_OFS_VER)*8 +: 8] = rx_data_in;
        end
      endcase
      if (ridx_r != OIN_RQ_IDX_MAX)
        ridx_nxt = ridx_r + 5'h01;
      if (rx_last_in)
      begin
        ridx_nxt = 5'h00;
        oseq_nxt = rseq_nxt;
        ocmd_nxt = rcmd_nxt;
        over_nxt = rver_nxt;
        // Misaddressed frames and frames under 3 bytes raise no pulse, but still update the seq, cmd and version outputs
        if (addr_ok_nxt && (ridx_r >= 5'h02))
        begin
          if ((rfc_nxt == OIN_FC_CLIENT) && (rcmd_nxt == OIN_CMD_QUERY_NEXT) &&
              (ridx_r >= OIN_RQ_MIN_LEN - 5'h01))
            rq_nxt = 1'b1;
          else
            ro_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ridx_r <= 5'h00;
      addr_ok_r <= 1'b0;
      rfc_r <= 8'h00;
      rseq_r <= 8'h00;
      rcmd_r <= 8'h00;
      rver_r <= 32'h0000_0000;
      rq_r <= 1'b0;
      ro_r <= 1'b0;
      oseq_r <= 8'h00;
      ocmd_r <= 8'h00;
      over_r <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      ridx_r <= ridx_nxt;
      addr_ok_r <= addr_ok_nxt;
      rfc_r <= rfc_nxt;
      rseq_r <= rseq_nxt;
      rcmd_r <= rcmd_nxt;
      rver_r <= rver_nxt;
      rq_r <= rq_nxt;
      ro_r <= ro_nxt;
      oseq_r <= oseq_nxt;
      ocmd_r <= ocmd_nxt;
      over_r <= over_nxt;
    end
  end

  // ****************
  // Upgrade file sub-element parser
  // ****************
  oin_tlv_parser u_tlv (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .restart_in(file_restart_in),
    .byte_valid_in(file_valid_in),
    .byte_in(file_data_in),
    .hdr_done_out(file_hdr_done_out),
    .tag_out(file_tag_out),
    .length_out(file_length_out),
    .is_image_out(file_is_image_out),
    .data_valid_out(file_data_valid_out),
    .data_out(file_data_out),
    .data_last_out(file_data_last_out)
  );

  assign tx_valid_out = tv_r;
  assign tx_data_out = td_r;
  assign tx_last_out = tl_r;
  assign tx_broadcast_out = bc_r;
  assign busy_out = (tx_state_r != OIN_TX_IDLE);
  assign tx_src_ep_out = OIN_ENDPOINT;
  assign tx_dst_ep_out = OIN_ENDPOINT;
  assign tx_cluster_out = OIN_CLUSTER_ID;
  assign tx_profile_out = OIN_PROFILE_ID;
  assign notify_compat_out = ver_r[31:24];
  assign notify_fw_out = ver_r[23:0];
  assign notify_fs_out = (it_r == OIN_ITYPE_FILESYS);
  assign rx_query_out = rq_r;
  assign rx_other_out = ro_r;
  assign rx_seq_out = oseq_r;
  assign rx_cmd_out = ocmd_r;
  assign rx_compat_out = over_r[31:24];
  assign rx_fw_out = over_r[23:0];
endmodule

// >>> include/oin_pkg.sv
package oin_pkg;
  // ****************
  // Addressing of every upgrade packet
  // ****************
  localparam logic [7:0] OIN_ENDPOINT = 8'hE8;
  localparam logic [15:0] OIN_CLUSTER_ID = 16'h0019;
  localparam logic [15:0] OIN_PROFILE_ID = 16'hC105;

  // ****************
  // Command header
  // ****************
  localparam logic [7:0] OIN_FC_UNICAST = 8'h09;
  localparam logic [7:0] OIN_FC_BROADCAST = 8'h19;
  localparam logic [7:0] OIN_FC_CLIENT = 8'h01;
  localparam logic [7:0] OIN_CMD_NOTIFY = 8'h00;
  localparam logic [7:0] OIN_CMD_QUERY_NEXT = 8'h01;
  localparam logic [7:0] OIN_JITTER_MAX = 8'h64;
  localparam logic [7:0] OIN_PTYPE_MAX = 8'h03;

  // ****************
  // Image Notify byte offsets and lengths per payload type
  // ****************
  localparam logic [3:0] OIN_OFS_FC = 4'h0;
  localparam logic [3:0] OIN_OFS_SEQ = 4'h1;
  localparam logic [3:0] OIN_OFS_CMD = 4'h2;
  localparam logic [3:0] OIN_OFS_PTYPE = 4'h3;
  localparam logic [3:0] OIN_OFS_JITTER = 4'h4;
  localparam logic [3:0] OIN_OFS_MFR = 4'h5;
  localparam logic [3:0] OIN_OFS_ITYPE = 4'h7;
  localparam logic [3:0] OIN_OFS_VER = 4'h9;
  localparam logic [3:0] OIN_LEN_PT0 = 4'h5;
  localparam logic [3:0] OIN_LEN_PT1 = 4'h7;
  localparam logic [3:0] OIN_LEN_PT2 = 4'h9;
  localparam logic [3:0] OIN_LEN_PT3 = 4'hD;

  // ****************
  // Query Next Image Request offsets
  // ****************
  localparam logic [4:0] OIN_RQ_OFS_VER = 5'h08;
  localparam logic [4:0] OIN_RQ_MIN_LEN = 5'h0C;
  localparam logic [4:0] OIN_RQ_IDX_MAX = 5'h1F;

  // ****************
  // Image types and sub-element layout
  // ****************
  localparam logic [15:0] OIN_ITYPE_FIRMWARE = 16'h0000;
  localparam logic [15:0] OIN_ITYPE_FILESYS = 16'h0100;
  localparam logic [15:0] OIN_TAG_IMAGE = 16'h0000;
  localparam logic [2:0] OIN_TLV_OFS_LEN = 3'h2;
  localparam logic [2:0] OIN_TLV_OFS_DATA = 3'h6;

  typedef enum logic [2:0] {
    OIN_TX_IDLE = 3'h1,
    OIN_TX_LOAD = 3'h2,
    OIN_TX_SEND = 3'h4
  } oin_tx_state_type;

  typedef enum logic [1:0] {
    OIN_TLV_HDR = 2'h1,
    OIN_TLV_DATA = 2'h2
  } oin_tlv_state_type;
endpackage

// >>> rtl/oin_tlv_parser.sv
`timescale 1ns/10ps
module oin_tlv_parser
  import oin_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic restart_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic hdr_done_out,
  output logic [15:0] tag_out,
  output logic [31:0] length_out,
  output logic is_image_out,
  output logic data_valid_out,
  output logic [7:0] data_out,
  output logic data_last_out
);
  oin_tlv_state_type state_r, state_nxt;
  logic [2:0] hidx_r, hidx_nxt;
  logic [31:0] left_r, left_nxt;
  logic hdr_done_r, hdr_done_nxt;
  logic [15:0] tag_r, tag_nxt;
  logic [31:0] len_r, len_nxt;
  logic img_r, img_nxt;
  logic dv_r, dv_nxt;
  logic [7:0] data_r, data_nxt;
  logic dl_r, dl_nxt;

  always_comb
  begin
    state_nxt = state_r;
    hidx_nxt = hidx_r;
    left_nxt = left_r;
    hdr_done_nxt = 1'b0;
    tag_nxt = tag_r;
    len_nxt = len_r;
    img_nxt = img_r;
    dv_nxt = 1'b0;
    data_nxt = data_r;
    dl_nxt = 1'b0;
    if (restart_in)
    begin
      state_nxt = OIN_TLV_HDR;
      hidx_nxt = 3'h0;
    end
    else if (byte_valid_in)
    begin
      case (state_r)
        OIN_TLV_HDR:
        begin
          // Tag then length, both least significant byte first
          if (hidx_r < OIN_TLV_OFS_LEN)
            tag_nxt[hidx_r[0]*8 +: 8] = byte_in;
          else
            len_nxt[(hidx_r - OIN_TLV_OFS_LEN)*8 +: 8] = byte_in;
          hidx_nxt = hidx_r + 3'h1;
          if (hidx_nxt == OIN_TLV_OFS_DATA)
          begin
            hdr_done_nxt = 1'b1;
            img_nxt = (tag_nxt == OIN_TAG_IMAGE);
            left_nxt = len_nxt;
            hidx_nxt = 3'h0;
            // A zero-length element has no data; the next header follows at once
            if (len_nxt != 32'h0)
              state_nxt = OIN_TLV_DATA;
          end
        end
        OIN_TLV_DATA:
        begin
          dv_nxt = 1'b1;
          data_nxt = byte_in;
          left_nxt = left_r - 32'h1;
          if (left_r == 32'h1)
          begin
            dl_nxt = 1'b1;
            state_nxt = OIN_TLV_HDR;
          end
        end
        default:
        begin
          state_nxt = OIN_TLV_HDR;
          hidx_nxt = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_r <= OIN_TLV_HDR;
      hidx_r <= 3'h0;
      left_r <= 32'h0;
      hdr_done_r <= 1'b0;
      tag_r <= 16'h0;
      len_r <= 32'h0;
      img_r <= 1'b0;
      dv_r <= 1'b0;
      data_r <= 8'h0;
      dl_r <= 1'b0;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
      hidx_r <= hidx_nxt;
      left_r <= left_nxt;
      hdr_done_r <= hdr_done_nxt;
      tag_r <= tag_nxt;
      len_r <= len_nxt;
      img_r <= img_nxt;
      dv_r <= dv_nxt;
      data_r <= data_nxt;
      dl_r <= dl_nxt;
    end
  end

  assign hdr_done_out = hdr_done_r;
  assign tag_out = tag_r;
  assign length_out = len_r;
  assign is_image_out = img_r;
  assign data_valid_out = dv_r;
  assign data_out = data_r;
  assign data_last_out = dl_r;
endmodule

// >>> bench/oin_notify_checker.sv
`timescale 1ns/10ps
module oin_notify_checker
  import oin_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_last_out,
  input wire logic tx_broadcast_out,
  input wire logic busy_out,
  input wire logic [7:0] tx_src_ep_out,
  input wire logic [7:0] tx_dst_ep_out,
  input wire logic [15:0] tx_cluster_out,
  input wire logic [15:0] tx_profile_out,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  input wire logic rx_query_out,
  input wire logic rx_other_out,
  input wire logic [7:0] rx_cmd_out,
  input wire logic file_hdr_done_out,
  input wire logic [15:0] file_tag_out,
  input wire logic file_is_image_out
);
  // ****************
  // Byte position and payload type of the frame
  // ****************
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [7:0] pt_r;
  logic [7:0] pt_nxt;

  always_comb
  begin
    idx_nxt = idx_r;
    pt_nxt = pt_r;
    if (ce_in && tx_valid_out && tx_ready_in)
    begin
      idx_nxt = tx_last_out ? 4'h0 : idx_r + 4'h1;
      if (idx_r == 4'h3)
        pt_nxt = tx_data_out;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      idx_r <= 4'h0;
      pt_r <= 8'h00;
    end
    else
    begin
      idx_r <= idx_nxt;
      pt_r <= pt_nxt;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // ****************
  // Properties
  // ****************
  chk_addr_fixed: assert property (
    tx_src_ep_out == 8'hE8 && tx_dst_ep_out == 8'hE8 && tx_cluster_out == 16'h0019
    && tx_profile_out == 16'hC105) else $error("fixed addressing wrong");
  chk_start_answer: assert property (
    start_in && ce_in && !busy_out |-> ##2 tx_valid_out) else $error("notify not started");
  chk_first_fc: assert property ($rose(tx_valid_out) |->
    tx_data_out == (tx_broadcast_out ? 8'h19 : 8'h09)) else $error("frame control wrong");
  chk_byte_hold: assert property (tx_valid_out && !tx_ready_in && ce_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out)) else $error("byte not held");
  chk_cmd_byte: assert property (
    tx_valid_out && idx_r == 4'h2 |-> tx_data_out == 8'h00) else $error("command id wrong");
  chk_ptype_range: assert property (
    tx_valid_out && idx_r == 4'h3 |-> tx_data_out <= 8'h03) else $error("payload type wrong");
  chk_jitter_value: assert property (tx_valid_out && idx_r == 4'h4 |->
    tx_data_out <= 8'h64 && (tx_broadcast_out || tx_data_out == 8'h64))
    else $error("jitter wrong");
  chk_frame_len: assert property (tx_valid_out && tx_last_out |->
    idx_r + 4'h1 == (pt_r == 8'h00 ? 4'h5 : pt_r == 8'h01 ? 4'h7 : pt_r == 8'h02 ? 4'h9 : 4'hD))
    else $error("frame length wrong");
  chk_idle_quiet: assert property (
    !busy_out |-> !tx_valid_out) else $error("valid while idle");
  chk_rx_after_last: assert property (
    rx_query_out || rx_other_out |-> $past(rx_valid_in && rx_last_in && ce_in))
    else $error("pulse without frame end");
  chk_query_cmd: assert property (
    rx_query_out |-> rx_cmd_out == 8'h01 && !rx_other_out) else $error("query decode wrong");
  chk_tag_image: assert property (file_hdr_done_out |->
    file_is_image_out == (file_tag_out == 16'h0000)) else $error("image tag wrong");

  cover property (rx_query_out);
  cover property (rx_other_out);
  cover property (tx_last_out && tx_broadcast_out);
  cover property (file_hdr_done_out && file_is_image_out);
endmodule

bind oin_notify_server oin_notify_checker chk_i (.*);

// >>> bench/oin_client_model.sv
`timescale 1ns/10ps
module oin_client_model
  import oin_pkg::*;
#(
  // Maker code value is arbitrary
  parameter logic [15:0] MY_MFR = 16'h5A3C,
  parameter logic [15:0] MY_ITYPE = 16'h0000,
  parameter logic [31:0] MY_VER = 32'h0300400C,
  parameter logic [7:0] DEF_CMD = 8'h0B,
  parameter logic [7:0] DEF_STATUS = 8'h01
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic bad_addr_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic [15:0] tx_cluster_in,
  input wire logic [15:0] tx_profile_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  output logic [7:0] rx_ep_out,
  output logic [15:0] rx_cluster_out,
  output logic [15:0] rx_profile_out
);
  logic [7:0] b [0:12];
  logic [95:0] rsp;
  logic [6:0] draw;
  logic [7:0] own_seq;
  logic tog;
  logic match;
  int n, rn, ri, rt;

  // Wrong cluster only on request
  assign rx_ep_out = OIN_ENDPOINT;
  assign rx_cluster_out = bad_addr_in ? 16'h0018 : OIN_CLUSTER_ID;
  assign rx_profile_out = OIN_PROFILE_ID;

  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      n = 0;
      rn = 0;
      ri = 0;
      rt = 1;
      own_seq = 8'h00;
      draw <= 7'h00;
      tog <= 1'b0;
      tx_ready_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_last_out <= 1'b0;
      rx_data_out <= 8'h00;
    end
    else
    begin
      // Sweeps 0..99 evenly, so the reply share equals the jitter
      draw <= (draw == 7'h63) ? 7'h00 : draw + 7'h01;
      tog <= ~tog;
      tx_ready_out <= slow_in ? tog : 1'b1;
      if (ri < rn * rt)
      begin
        rx_valid_out <= 1'b1;
        rx_data_out <= rsp[95 - 8 * (ri % rn) -: 8];
        rx_last_out <= (ri % rn == rn - 1);
        ri = ri + 1;
      end
      else
      begin
        rx_valid_out <= 1'b0;
        rx_last_out <= 1'b0;
        rx_data_out <= ~rx_data_out;
      end
      if (tx_valid_in && tx_ready_out)
      begin
        b[n] = tx_data_in;
        n = n + 1;
        if (tx_last_in)
        begin
          n = 0;
          match = (b[3] < 8'h01 || {b[6], b[5]} == MY_MFR)
            && (b[3] < 8'h02 || {b[8], b[7]} == MY_ITYPE)
            && (b[3] < 8'h03 || {b[12], b[11], b[10], b[9]} == MY_VER);
          if (b[2] != OIN_CMD_NOTIFY || tx_cluster_in != OIN_CLUSTER_ID ||
              tx_profile_in != OIN_PROFILE_ID)
            rn = 0;
          else if (b[0] == OIN_FC_BROADCAST)
            rn = (match && (b[4] >= 8'h64 || {1'b0, draw} < b[4])) ? 12 : 0;
          else
            rn = match ? 12 : 5;
          // This block never answers, so a query is sent twice and then abandoned
          rt = (rn == 12) ? 2 : 1;
          own_seq = own_seq + 8'h01;
          rsp = (rn == 12) ? {8'h01, own_seq, 8'h01, 8'h00, MY_MFR[7:0], MY_MFR[15:8],
            MY_ITYPE[7:0], MY_ITYPE[15:8], MY_VER[7:0], MY_VER[15:8], MY_VER[23:16],
            MY_VER[31:24]} : {8'h08, own_seq, DEF_CMD, b[2], DEF_STATUS, 56'h0};
          ri = 0;
        end
      end
    end
  end
endmodule

// >>> bench/oin_notify_server_tb.sv
`timescale 1ns/10ps
module oin_notify_server_tb;
  import oin_pkg::*;
  localparam logic [15:0] MY_MFR = 16'h5A3C;
  localparam logic [31:0] MY_VER = 32'h0300400C;
  logic clock_in, rst_in, ce_in, start_in, broadcast_in, tx_ready_in, tx_valid_out;
  logic tx_last_out, tx_broadcast_out, busy_out, notify_fs_out, rx_valid_in, rx_last_in;
  logic rx_query_out, rx_other_out, file_restart_in, file_valid_in, file_hdr_done_out;
  logic file_is_image_out, file_data_valid_out, file_data_last_out, slow, bad_addr;
  logic [7:0] seq_in, payload_type_in, jitter_in, tx_data_out, tx_src_ep_out, tx_dst_ep_out;
  logic [7:0] notify_compat_out, rx_data_in, rx_src_ep_in, rx_dst_ep_in, rx_seq_out;
  logic [7:0] rx_cmd_out, rx_compat_out, file_data_in, file_data_out, sq;
  logic [15:0] mfr_code_in, image_type_in, tx_cluster_out, tx_profile_out;
  logic [15:0] rx_cluster_in, rx_profile_in, file_tag_out;
  logic [23:0] notify_fw_out, rx_fw_out;
  logic [31:0] file_version_in, file_length_out;
  logic [7:0] fr[$];
  logic [48:0] hq[$];
  logic [8:0] fq[$];
  int n_errors = 0;
  int n_checks = 0;
  int n_q = 0;
  int n_o = 0;
  int cyc = 0;

  assign rx_dst_ep_in = rx_src_ep_in;

  oin_notify_server uut (.*);

  oin_client_model #(.MY_MFR(MY_MFR), .MY_VER(MY_VER)) peer (
    .clock_in(clock_in), .rst_in(rst_in), .slow_in(slow), .bad_addr_in(bad_addr),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_last_in(tx_last_out),
    .tx_cluster_in(tx_cluster_out), .tx_profile_in(tx_profile_out),
    .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .rx_last_out(rx_last_in), .rx_ep_out(rx_src_ep_in), .rx_cluster_out(rx_cluster_in),
    .rx_profile_out(rx_profile_in));

  // ****************
  // Monitors and shared tasks
  // ****************
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      final_report();
    end
    if (!rst_in && tx_valid_out && tx_ready_in)
      fr.push_back(tx_data_out);
    if (rx_query_out === 1'b1)
      n_q++;
    if (rx_other_out === 1'b1)
      n_o++;
    if (file_hdr_done_out === 1'b1)
      hq.push_back({file_is_image_out, file_tag_out, file_length_out});
    if (file_data_valid_out === 1'b1)
      fq.push_back({file_data_last_out, file_data_out});
  end

  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic notify(input logic bc, input logic [7:0] pt, input logic [7:0] jit,
    input logic [15:0] mf, input logic [15:0] it, input logic [31:0] vr, input int rsp);
    logic [7:0] ex[$];
    int q0;
    int o0;
    sq = sq + 8'h11;
    ex = {bc ? 8'h19 : 8'h09, sq, 8'h00, (pt > 8'h03) ? 8'h03 : pt,
      (!bc || jit > 8'h64) ? 8'h64 : jit};
    if (pt >= 8'h01)
      ex = {ex, mf[7:0], mf[15:8]};
    if (pt >= 8'h02)
      ex = {ex, it[7:0], it[15:8]};
    if (pt >= 8'h03)
      ex = {ex, vr[7:0], vr[15:8], vr[23:16], vr[31:24]};
    fr = {};
    q0 = n_q;
    o0 = n_o;
    broadcast_in <= bc;
    seq_in <= sq;
    payload_type_in <= pt;
    jitter_in <= jit;
    mfr_code_in <= mf;
    image_type_in <= it;
    file_version_in <= vr;
    start_in <= 1'b1;
    @(posedge clock_in);
    start_in <= 1'b0;
    for (int k = 0; k < 100 && fr.size() < ex.size(); k++)
      @(posedge clock_in);
    // Room for two 12-byte replies and their pulses
    repeat (40) @(posedge clock_in);
    check("frame length", fr.size(), ex.size());
    foreach (ex[i])
      check("frame byte", fr[i], ex[i]);
    check("query count", n_q - q0, (rsp == 1) ? 2 : 0);
    check("other count", n_o - o0, rsp == 2);
    if (pt >= 8'h02)
      check("fs flag", notify_fs_out, it == 16'h0100);
    if (pt >= 8'h03)
      check("notify version", {notify_compat_out, notify_fw_out}, vr);
    if (rsp == 1)
      check("rx query", {rx_cmd_out, rx_compat_out, rx_fw_out}, {8'h01, MY_VER});
    if (rsp == 2)
      check("rx other cmd", rx_cmd_out, 8'h0B);
    if (rsp != 0)
      check("rx seq", rx_seq_out, sq / 8'h11);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_unicast_modes();
    // Type 4 goes out as type 3
    for (int p = 0; p < 5; p++)
      notify(1'b0, p[7:0], 8'h32, MY_MFR, 16'h0000, MY_VER, 1);
  endtask

  task automatic t_unicast_bad();
    slow <= 1'b1;
    notify(1'b0, 8'h02, 8'h64, MY_MFR, 16'h0100, MY_VER, 2);
    notify(1'b0, 8'h03, 8'h64, MY_MFR, 16'h0000, MY_VER + 32'h1, 2);
    notify(1'b0, 8'h01, 8'h64, 16'h1234, 16'h0000, MY_VER, 2);
    slow <= 1'b0;
    bad_addr <= 1'b1;
    notify(1'b0, 8'h00, 8'h64, 16'h0000, 16'h0000, 32'h0, 0);
    bad_addr <= 1'b0;
  endtask

  task automatic t_broadcast();
    notify(1'b1, 8'h00, 8'h64, 16'h0000, 16'h0000, 32'h0, 1);
    notify(1'b1, 8'h03, 8'hC8, MY_MFR, 16'h0000, MY_VER, 1);
    notify(1'b1, 8'h01, 8'h64, 16'h1234, 16'h0000, 32'h0, 0);
    notify(1'b1, 8'h00, 8'h00, 16'h0000, 16'h0000, 32'h0, 0);
  endtask

  task automatic t_file();
    logic [7:0] s[$];
    logic [8:0] ev[$];
    s = {8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'hAA, 8'hBB,
      8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h5C};
    ev = {9'h0AA, 9'h1BB, 9'h15C};
    file_restart_in <= 1'b1;
    @(posedge clock_in);
    file_restart_in <= 1'b0;
    foreach (s[i])
    begin
      file_valid_in <= 1'b1;
      file_data_in <= s[i];
      @(posedge clock_in);
    end
    file_valid_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    check("headers", hq.size(), 2);
    check("first header", hq[0], {1'b1, 16'h0000, 32'h2});
    check("second header", hq[1], {1'b0, 16'h0001, 32'h1});
    check("data count", fq.size(), 3);
    foreach (ev[i])
      check("data byte", fq[i], ev[i]);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  initial
  begin
    {rst_in, ce_in, start_in, broadcast_in, file_restart_in, file_valid_in} = 6'h30;
    {slow, bad_addr, seq_in, payload_type_in, jitter_in, file_data_in, sq} = 42'h0;
    {mfr_code_in, image_type_in, file_version_in} = 64'h0;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    check("idle after reset", {busy_out, tx_valid_out, rx_query_out}, 3'h0);
    t_unicast_modes();
    t_unicast_bad();
    t_broadcast();
    t_file();
    final_report();
  end
endmodule
